/* File: core/rxdec_pkg.sv */
// Purpose: shared constants for the receiver and decoder control bank
// Assumes: 8-bit processor register port, 10 MHz system clock
// Notes: offsets are the byte addresses of the parallel register port
package rxdec_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int LEVEL_W = 4;
	localparam int TAPS_W = 5;

	// Register offsets
	localparam logic [5:0] OFS_TX_RX_CLOCK_PHASE = 6'h1b;
	localparam logic [5:0] OFS_DECODER_THRESHOLDS = 6'h1c;
	localparam logic [5:0] OFS_RESERVED_PRESET_1D = 6'h1d;
	localparam logic [5:0] OFS_RECEIVER_SOURCE_CONTROL = 6'h1e;
	localparam logic [5:0] OFS_QUADRATURE_CLOCK_CONTROL = 6'h1f;

	// Reset values
	localparam logic [7:0] RST_TX_RX_CLOCK_PHASE = 8'had;
	localparam logic [7:0] RST_DECODER_THRESHOLDS = 8'hff;
	localparam logic [7:0] RST_RESERVED_PRESET_1D = 8'h00;
	localparam logic [7:0] RST_RECEIVER_SOURCE_CONTROL = 8'h41;
	localparam logic [4:0] RST_QUAD_CLOCK_DELAY_TAPS = 5'h00;
	localparam logic RST_QUAD_CLOCK_CAL_DISABLE = 1'b0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Field positions
	localparam int MIN_LEVEL_LSB = 4;
	localparam int COLL_LEVEL_LSB = 0;
	localparam int RX_CLK_SEL_BIT = 7;
	localparam int RX_AUTO_PD_BIT = 6;
	localparam int RX_RSVD_LSB = 2;
	localparam int RX_RSVD_W = 4;
	localparam int DEC_SRC_LSB = 0;
	localparam int QC_HALF_TURN_BIT = 7;
	localparam int QC_CAL_DIS_BIT = 6;
	localparam int QC_RSVD_BIT = 5;
	localparam int QC_TAPS_LSB = 0;

	// Decoder input sources
	localparam logic [1:0] SRC_LOW = 2'h0;
	localparam logic [1:0] SRC_DEMOD = 2'h1;
	localparam logic [1:0] SRC_AUX_SUBCARRIER = 2'h2;
	localparam logic [1:0] SRC_AUX_BASEBAND = 2'h3;

	// Calibration settle time per delay-line step
	localparam int CLK_PERIOD_NS = 100;
	localparam int CAL_SETTLE_NS = 1000;
	localparam int CAL_SETTLE_CYCLES =
		(CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : rxdec_pkg

/* File: core/quad_clock_calibrator.sv */
// Purpose: steps the quadrature delay line until a quarter turn is reached
// Assumes: phase_past_quarter already synchronised to the system clock
// Notes: result holds the smallest tap count showing a quarter-turn lag, or all ones if no count does
`timescale 1ns/1ps
module quad_clock_calibrator #(
	parameter int TAPS_W = rxdec_pkg::TAPS_W,
	parameter int SETTLE = rxdec_pkg::CAL_SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic phase_past_quarter,
	output logic busy,
	output logic done,
	output logic [TAPS_W-1:0] trial,
	output logic [TAPS_W-1:0] result
);
	typedef enum logic {CAL_IDLE, CAL_WAIT} cal_state_t;

	localparam logic [TAPS_W-1:0] TAPS_MAX = {TAPS_W{1'b1}};
	localparam logic [7:0] SETTLE_LAST = 8'(SETTLE - 1);

	cal_state_t state;
	logic [7:0] settle;

	assign busy = (state == CAL_WAIT);

	// Step sequencer: settle, sample, then advance or finish
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!nrst) begin
			state <= CAL_IDLE;
			settle <= 8'h00;
			trial <= '0;
			result <= '0;
		end else begin
			unique case (state)
				CAL_IDLE: begin
					if (start) begin
						state <= CAL_WAIT;
						trial <= '0;
						settle <= 8'h00;
					end
				end
				CAL_WAIT: begin
					if (settle != SETTLE_LAST) begin
						settle <= settle + 8'h01;
					end else if (phase_past_quarter || trial == TAPS_MAX) begin
						result <= trial;
						done <= 1'b1;
						state <= CAL_IDLE;
					end else begin
						trial <= trial + 1'b1;
						settle <= 8'h00;
					end
				end
			endcase
		end
	end
endmodule : quad_clock_calibrator

/* File: core/receiver_decoder_control_regs.sv */
// Purpose: receiver and decoder control registers 1Bh to 1Fh
// Assumes: single-cycle write and read strobes from the processor port
// Notes: decoder levels and demodulator bit come from same-clock logic
// Function
// - Register 1Bh, reset ADh, sets transmit/receive clock phase.
// - Decoder ignores signals weaker than the minimum level in bits 7:4.
// - Collision flagged only when weaker half-bit reaches level in bits 3:0.
// - Bit 7 of 1Eh: 1 in-phase, 0 quadrature receiver clock.
// - Bit 6 of 1Eh: auto power around reception, else always on.
// - Bits 1:0 pick decoder input: low, demodulator, aux subcarrier, baseband.
// - Register 1Eh resets to 41h; reserved bits 5:2 reset to zero but take written values.
// - Bit 7 of 1Fh reads whether quadrature lag exceeds a half turn.
// - Bit 6 of 1Fh clear: calibrate after reset and each reception.
// - Bits 4:0 of 1Fh hold delay taps, written by processor or calibration.
// - Register 1Fh resets with upper three bits zero; bit 5 resets to zero but takes written values.
`timescale 1ns/1ps
module receiver_decoder_control_regs #(
	parameter int SETTLE = rxdec_pkg::CAL_SETTLE_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic [5:0] ADDR,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	input wire logic [3:0] SIGNAL_LEVEL,
	input wire logic [3:0] WEAK_HALF_LEVEL,
	input wire logic DEMOD_BIT,
	input wire logic AUX_MANCHESTER_INPUT,
	input wire logic RX_ACTIVE,
	input wire logic RX_DONE,
	input wire logic QUAD_PAST_QUARTER,
	input wire logic QUAD_PAST_HALF,
	output logic [7:0] TX_RX_CLOCK_PHASE,
	output logic RECEIVER_CLOCK_SELECT,
	output logic RECEIVER_POWER_ON,
	output logic DECODER_INPUT,
	output logic DECODER_BASEBAND,
	output logic SIGNAL_ACCEPT,
	output logic COLLISION_FLAG,
	output logic [4:0] QUAD_CLOCK_DELAY_TAPS,
	output logic CAL_BUSY
);
	logic [7:0] decoder_thresholds;
	logic [7:0] reserved_preset_1d;
	logic receiver_auto_powerdown;
	logic [3:0] rx_reserved;
	logic [1:0] decoder_input_select;
	logic quad_clock_cal_disable;
	logic qc_reserved;
	logic [4:0] quad_clock_delay_taps;
	logic [1:0] aux_sync, quarter_sync, half_sync;
	logic quad_clock_over_half_turn;
	logic cal_pending, cal_start, cal_done;
	logic [4:0] cal_trial, cal_result;
	logic [3:0] min_signal_threshold, collision_threshold;

	// Write decode shared by every register
	function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign min_signal_threshold = decoder_thresholds[rxdec_pkg::MIN_LEVEL_LSB +:
		rxdec_pkg::LEVEL_W];
	assign collision_threshold = decoder_thresholds[rxdec_pkg::COLL_LEVEL_LSB +:
		rxdec_pkg::LEVEL_W];
	assign quad_clock_over_half_turn = half_sync[1];

	// Pin and analog comparator synchronisers
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			aux_sync <= 2'h0;
			quarter_sync <= 2'h0;
			half_sync <= 2'h0;
		end else begin
			aux_sync <= {aux_sync[0], AUX_MANCHESTER_INPUT};
			quarter_sync <= {quarter_sync[0], QUAD_PAST_QUARTER};
			half_sync <= {half_sync[0], QUAD_PAST_HALF};
		end
	end

	// Phase, threshold and reserved registers
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			TX_RX_CLOCK_PHASE <= rxdec_pkg::RST_TX_RX_CLOCK_PHASE;
			decoder_thresholds <= rxdec_pkg::RST_DECODER_THRESHOLDS;
			reserved_preset_1d <= rxdec_pkg::RST_RESERVED_PRESET_1D;
		end else if (WR_EN) begin
			if (hit(ADDR, rxdec_pkg::OFS_TX_RX_CLOCK_PHASE))
				TX_RX_CLOCK_PHASE <= WDATA;
			if (hit(ADDR, rxdec_pkg::OFS_DECODER_THRESHOLDS))
				decoder_thresholds <= WDATA;
			if (hit(ADDR, rxdec_pkg::OFS_RESERVED_PRESET_1D))
				reserved_preset_1d <= WDATA;
		end
	end

	// Receiver source control register
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			{RECEIVER_CLOCK_SELECT, receiver_auto_powerdown, rx_reserved,
				decoder_input_select} <= rxdec_pkg::RST_RECEIVER_SOURCE_CONTROL;
		end else if (WR_EN &&
			hit(ADDR, rxdec_pkg::OFS_RECEIVER_SOURCE_CONTROL)) begin
			RECEIVER_CLOCK_SELECT <= WDATA[rxdec_pkg::RX_CLK_SEL_BIT];
			receiver_auto_powerdown <= WDATA[rxdec_pkg::RX_AUTO_PD_BIT];
			rx_reserved <= WDATA[rxdec_pkg::RX_RSVD_LSB +: rxdec_pkg::RX_RSVD_W];
			decoder_input_select <= WDATA[rxdec_pkg::DEC_SRC_LSB +: 2];
		end
	end

	// Quadrature clock control; calibration result wins over a write
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			quad_clock_cal_disable <= rxdec_pkg::RST_QUAD_CLOCK_CAL_DISABLE;
			qc_reserved <= 1'b0;
			quad_clock_delay_taps <= rxdec_pkg::RST_QUAD_CLOCK_DELAY_TAPS;
		end else begin
			if (WR_EN && hit(ADDR, rxdec_pkg::OFS_QUADRATURE_CLOCK_CONTROL)) begin
				quad_clock_cal_disable <= WDATA[rxdec_pkg::QC_CAL_DIS_BIT];
				qc_reserved <= WDATA[rxdec_pkg::QC_RSVD_BIT];
				quad_clock_delay_taps <= WDATA[rxdec_pkg::QC_TAPS_LSB +:
					rxdec_pkg::TAPS_W];
			end
			if (cal_done)
				quad_clock_delay_taps <= cal_result;
		end
	end

	// Calibration request after reset and after each reception
	assign cal_start = cal_pending && !quad_clock_cal_disable && !CAL_BUSY;
	always_ff @(posedge SYS_CLK) begin
		if (!NRST)
			cal_pending <= 1'b1;
		else
			cal_pending <= RX_DONE ||
				(cal_pending && !cal_start && !quad_clock_cal_disable);
	end

	quad_clock_calibrator #(
		.TAPS_W(rxdec_pkg::TAPS_W),
		.SETTLE(SETTLE)
	) u_cal (
		.clk(SYS_CLK),
		.nrst(NRST),
		.start(cal_start),
		.phase_past_quarter(quarter_sync[1]),
		.busy(CAL_BUSY),
		.done(cal_done),
		.trial(cal_trial),
		.result(cal_result)
	);

	// Delay line: trial count while calibrating, result in the done cycle
	// so the line never falls back to the stale count for one cycle
	assign QUAD_CLOCK_DELAY_TAPS = CAL_BUSY ? cal_trial :
		cal_done ? cal_result : quad_clock_delay_taps;

	// Receiver power follows reception when auto power-down is on
	assign RECEIVER_POWER_ON = !receiver_auto_powerdown || RX_ACTIVE;

	// Decoder input mux and level checks
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			DECODER_INPUT <= 1'b0;
			DECODER_BASEBAND <= 1'b0;
			SIGNAL_ACCEPT <= 1'b0;
			COLLISION_FLAG <= 1'b0;
		end else begin
			unique case (decoder_input_select)
				rxdec_pkg::SRC_LOW: DECODER_INPUT <= 1'b0;
				rxdec_pkg::SRC_DEMOD: DECODER_INPUT <= DEMOD_BIT;
				rxdec_pkg::SRC_AUX_SUBCARRIER: DECODER_INPUT <= aux_sync[1];
				rxdec_pkg::SRC_AUX_BASEBAND: DECODER_INPUT <= aux_sync[1];
			endcase
			DECODER_BASEBAND <= (decoder_input_select ==
				rxdec_pkg::SRC_AUX_BASEBAND);
			SIGNAL_ACCEPT <= (SIGNAL_LEVEL >= min_signal_threshold);
			COLLISION_FLAG <= (SIGNAL_LEVEL >= min_signal_threshold) &&
				(WEAK_HALF_LEVEL >= collision_threshold);
		end
	end

	// Registered read port; unmapped offsets read zero
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			RDATA <= rxdec_pkg::UNMAPPED_READ;
		end else if (RD_EN) begin
			unique case (ADDR)
				rxdec_pkg::OFS_TX_RX_CLOCK_PHASE: RDATA <= TX_RX_CLOCK_PHASE;
				rxdec_pkg::OFS_DECODER_THRESHOLDS: RDATA <= decoder_thresholds;
				rxdec_pkg::OFS_RESERVED_PRESET_1D: RDATA <= reserved_preset_1d;
				rxdec_pkg::OFS_RECEIVER_SOURCE_CONTROL:
					RDATA <= {RECEIVER_CLOCK_SELECT, receiver_auto_powerdown,
						rx_reserved, decoder_input_select};
				rxdec_pkg::OFS_QUADRATURE_CLOCK_CONTROL:
					RDATA <= {quad_clock_over_half_turn, quad_clock_cal_disable,
						qc_reserved, quad_clock_delay_taps};
				default: RDATA <= rxdec_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	AST_PHASE_WRITE: assert property (
		WR_EN && ADDR == rxdec_pkg::OFS_TX_RX_CLOCK_PHASE
		|=> TX_RX_CLOCK_PHASE == $past(WDATA))
		else $error("phase register write not taken");
	AST_MIN_LEVEL: assert property (
		SIGNAL_LEVEL < min_signal_threshold |=> !SIGNAL_ACCEPT && !COLLISION_FLAG)
		else $error("weak signal accepted");
	AST_COLLISION: assert property (
		COLLISION_FLAG |-> $past(WEAK_HALF_LEVEL) >= $past(collision_threshold))
		else $error("collision below threshold");
	AST_CLOCK_SEL: assert property (
		WR_EN && ADDR == rxdec_pkg::OFS_RECEIVER_SOURCE_CONTROL
		|=> RECEIVER_CLOCK_SELECT == $past(WDATA[rxdec_pkg::RX_CLK_SEL_BIT]))
		else $error("receiver clock select not updated");
	AST_POWER: assert property (
		!receiver_auto_powerdown || RX_ACTIVE |-> RECEIVER_POWER_ON)
		else $error("receiver powered down");
	AST_SRC_LOW: assert property (
		decoder_input_select == rxdec_pkg::SRC_LOW |=> !DECODER_INPUT)
		else $error("decoder input not low");
	AST_RX_RESET: assert property (@(posedge SYS_CLK) disable iff (1'b0)
		!NRST |=> {RECEIVER_CLOCK_SELECT, receiver_auto_powerdown, rx_reserved,
			decoder_input_select} == rxdec_pkg::RST_RECEIVER_SOURCE_CONTROL)
		else $error("receiver control reset value wrong");
	AST_HALF_TURN: assert property (
		RD_EN && ADDR == rxdec_pkg::OFS_QUADRATURE_CLOCK_CONTROL
		|=> RDATA[7] == $past(quad_clock_over_half_turn))
		else $error("half-turn status wrong");
	AST_CAL_START: assert property (
		RX_DONE && !quad_clock_cal_disable && !CAL_BUSY ##1
		!quad_clock_cal_disable |-> ##[0:2] CAL_BUSY)
		else $error("calibration did not start");
	AST_CAL_OVERWRITE: assert property (
		cal_done |=> quad_clock_delay_taps == $past(cal_result))
		else $error("calibration result lost");

	COV_CAL_DONE: cover property (cal_done);
	COV_COLLISION: cover property (COLLISION_FLAG);
	COV_AUX_BASEBAND: cover property (DECODER_BASEBAND && DECODER_INPUT);
endmodule : receiver_decoder_control_regs

/* File: sim/rf_front_model.sv */
// Purpose: front-end model: reception bursts and delay-line comparators
// Assumes: ideal delay line, quarter turn reached at TARGET taps
// Notes: comparator outputs are asynchronous, as on real pins
`timescale 1ns/1ps
module rf_front_model #(
	parameter int TARGET = 5,
	parameter int RX_LEN = 6
) (
	input wire logic clk,
	input wire logic rx_go,
	input wire logic [4:0] taps,
	output logic rx_active,
	output logic rx_done,
	output logic past_quarter,
	output logic past_half
);
	int count = 0;
	// Lag grows with taps, half turn beyond twice the quarter count
	assign past_quarter = taps >= TARGET;
	assign past_half = taps > 2 * TARGET;
	initial begin
		rx_active = 1'b0;
		rx_done = 1'b0;
	end
	// Burst of reception, one-cycle done pulse at its end
	always @(negedge clk) begin
		rx_done <= 1'b0;
		if (rx_go && !rx_active) begin
			rx_active <= 1'b1;
			count <= RX_LEN;
		end else if (rx_active) begin
			count <= count - 1;
			if (count == 1) begin
				rx_active <= 1'b0;
				rx_done <= 1'b1;
			end
		end
	end
endmodule : rf_front_model

/* File: sim/receiver_decoder_control_regs_tb.sv */
// Purpose: register, decoder and calibration tests of the bank
// Assumes: inputs change on falling edges, SETTLE shortened to 4
// Notes: front-end model closes the calibration loop
`timescale 1ns/1ps
module receiver_decoder_control_regs_tb;
	localparam int TARGET = 5;
	logic sys_clk;
	logic nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rx_go = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wdata = 8'h00, rdata, phase, v;
	logic [3:0] signal_level = 4'h0, weak_half_level = 4'h0;
	logic demod_bit = 1'b0, aux_in = 1'b0;
	logic rx_active, rx_done, past_q, past_h, clk_sel, pwr, dec_in;
	logic baseband, accept, coll, cal_busy;
	logic [4:0] taps;
	logic [9:0] lvl [5] = '{{4'h3, 4'hf, 2'b00}, {4'h4, 4'h5, 2'b10},
		{4'h4, 4'h6, 2'b11}, {4'hf, 4'h7, 2'b11}, {4'h3, 4'h9, 2'b00}};
	logic [7:0] mode [4] = '{8'h00, 8'h41, 8'hc2, 8'h83};
	int bad_count = 0;
	int checks = 0;
	receiver_decoder_control_regs #(.SETTLE(4))
		receiver_decoder_control_regs_inst (
		.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WR_EN(wr_en),
		.RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata),
		.SIGNAL_LEVEL(signal_level), .WEAK_HALF_LEVEL(weak_half_level),
		.DEMOD_BIT(demod_bit), .AUX_MANCHESTER_INPUT(aux_in),
		.RX_ACTIVE(rx_active), .RX_DONE(rx_done),
		.QUAD_PAST_QUARTER(past_q), .QUAD_PAST_HALF(past_h),
		.TX_RX_CLOCK_PHASE(phase), .RECEIVER_CLOCK_SELECT(clk_sel),
		.RECEIVER_POWER_ON(pwr), .DECODER_INPUT(dec_in),
		.DECODER_BASEBAND(baseband), .SIGNAL_ACCEPT(accept),
		.COLLISION_FLAG(coll), .QUAD_CLOCK_DELAY_TAPS(taps),
		.CAL_BUSY(cal_busy));
	rf_front_model #(.TARGET(TARGET)) rf_front_model_inst (
		.clk(sys_clk), .rx_go(rx_go), .taps(taps), .rx_active(rx_active),
		.rx_done(rx_done), .past_quarter(past_q), .past_half(past_h));
	// Clock of 100 ns period
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge sys_clk);
		wr_en = 1'b0;
	endtask : wr
	// Read after the synchronisers settle, then compare
	task automatic rc(input logic [5:0] a, input logic [7:0] exp,
		input string name);
		repeat (2) @(negedge sys_clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge sys_clk);
		rd_en = 1'b0;
		check(name, rdata, exp);
	endtask : rc
	task automatic receive();
		@(negedge sys_clk);
		rx_go <= 1'b1;
		@(negedge sys_clk);
		rx_go <= 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask : receive
	task automatic wait_cal();
		int n;
		n = 0;
		repeat (12) @(negedge sys_clk);
		while (cal_busy !== 1'b0 && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		check("cal_busy_end", cal_busy, 1'b0);
	endtask : wait_cal
	task automatic tally_and_finish();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	// Watchdog far beyond the expected run
	initial begin
		#2000000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (2) @(negedge sys_clk);
		check("cal_busy_start", cal_busy, 1'b1);
		check("phase_out", phase, 8'had);
		check("clk_sel", clk_sel, 1'b0);
		wait_cal();
		rc(6'h1b, 8'had, "phase");
		rc(6'h1c, 8'hff, "thresholds");
		rc(6'h1d, 8'h00, "preset");
		rc(6'h1e, 8'h41, "rx_ctrl");
		rc(6'h1f, 8'(TARGET), "quad_ctrl");
		wr(6'h1b, 8'h55);
		check("phase_out", phase, 8'h55);
		rc(6'h1b, 8'h55, "phase");
		wr(6'h10, 8'h5a);
		rc(6'h10, 8'h00, "unmapped");
		wr(6'h1d, 8'h00);
		rc(6'h1d, 8'h00, "preset");
		// Bit 7 written as 0 but reads the comparator
		wr(6'h1f, 8'h4c);
		check("taps_out", taps, 8'h0c);
		rc(6'h1f, 8'hcc, "quad_ctrl");
		wr(6'h1f, 8'hc3);
		rc(6'h1f, 8'h43, "quad_ctrl");
		receive();
		wait_cal();
		check("taps_kept", taps, 8'h03);
		wr(6'h1e, 8'h41);
		wr(6'h1f, 8'h03);
		receive();
		check("power_auto", pwr, 1'b1);
		wait_cal();
		check("taps_cal", taps, 8'(TARGET));
		rc(6'h1f, 8'(TARGET), "quad_ctrl");
		check("power_idle", pwr, 1'b0);
		wr(6'h1c, 8'h46);
		foreach (lvl[i]) begin
			@(negedge sys_clk);
			signal_level = lvl[i][9:6];
			weak_half_level = lvl[i][5:2];
			repeat (2) @(negedge sys_clk);
			check("accept", accept, lvl[i][1]);
			check("collision", coll, lvl[i][0]);
		end
		foreach (mode[i]) begin
			v = mode[i];
			wr(6'h1e, v);
			demod_bit = 1'b1;
			aux_in = 1'b0;
			repeat (4) @(negedge sys_clk);
			check("clk_sel", clk_sel, v[7]);
			check("power", pwr, !v[6]);
			check("baseband", baseband, v[1:0] == 2'h3);
			check("dec_demod", dec_in, v[1:0] == 2'h1);
			demod_bit = 1'b0;
			aux_in = 1'b1;
			repeat (4) @(negedge sys_clk);
			check("dec_aux", dec_in, v[1]);
		end
		tally_and_finish();
	end
endmodule : receiver_decoder_control_regs_tb
